// ### verilog/nvmac_top.sv
// Nonvolatile array access, control, protection and option registers.
`timescale 1ns/1ps
module nvmac_top
  import nvmac_pkg::*;
#(
  parameter bit MASK_VARIANT = 1'b0,
  parameter logic [7:0] OPT1_MASK_VAL = 8'h00,
  parameter logic [7:0] OPT2_MASK_VAL = 8'h00
)
(
  input wire logic sys_clk_i,            // System clock, 40 MHz.
  input wire logic sys_rst_i,            // Synchronous reset, active high.
  input wire logic [ADDR_W-1:0] addr_i,  // Register bus address.
  input wire logic [DATA_W-1:0] wdata_i, // Register bus write data.
  input wire logic wr_i,                 // Write strobe.
  input wire logic rd_i,                 // Read strobe.
  input wire logic [7:0] rst_cause_i,    // Reset causes, held in reset.
  input wire logic secure_lock_i,        // Array reads are blocked.
  output logic [DATA_W-1:0] rdata_o,     // Read data, cycle after strobe.
  output logic ready_o,                  // Start-up scan finished.
  output logic force_debug_o,            // Enter the debug loader.
  output logic [7:0] opt1_o,             // First option register.
  output logic [7:0] opt2_o              // Second option register.
);

  // ****************************************************************
  // Address decode helpers
  // ****************************************************************
  function automatic logic is_user(input logic [15:0] a);
    return (a >= USER_BASE) && (a <= USER_LAST);
  endfunction

  function automatic logic is_vec(input logic [15:0] a);
    return (a >= VEC_BASE) && (a <= VEC_LAST);
  endfunction

  // The protect byte exists only on the erasable part.
  function automatic logic in_array(input logic [15:0] a);
    return is_user(a) || is_vec(a) || (!MASK_VARIANT && a == PROT_ADDR);
  endfunction

  function automatic logic [IDX_W-1:0] arr_idx(input logic [15:0] a);
    logic [15:0] off;
    off = a - USER_BASE;
    if (is_vec(a))
    begin
      off = a - VEC_BASE;
      off = off + {4'h0, VEC_IDX};
    end
    else if (a == PROT_ADDR)
    begin
      off = {4'h0, PROT_IDX};
    end
    return off[IDX_W-1:0];
  endfunction

  // A page is two rows; the vector page and protect byte are short.
  function automatic logic [2*IDX_W-1:0] page_range(input logic [15:0] a);
    logic [IDX_W-1:0] lo;
    logic [IDX_W-1:0] hi;
    lo = arr_idx(a) & ~PAGE_MASK;
    hi = lo | PAGE_MASK;
    if (is_vec(a))
    begin
      lo = VEC_IDX;
      hi = VEC_IDX_LAST;
    end
    else if (a == PROT_ADDR)
    begin
      lo = PROT_IDX;
      hi = PROT_IDX;
    end
    return {hi, lo};
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  nvmac_state_t state_q;
  nvmac_state_t state_d;
  logic [7:0] ctrl_q;
  logic [7:0] rst_cause_q;
  logic [7:0] prot_q;
  logic [7:0] vec_hi_q;
  logic force_q;
  logic ready_q;
  logic run;
  logic arr_hit;
  logic prot_on;
  logic [15:0] prot_start;
  logic locked;
  logic prog_en;
  logic erase_en;
  logic [2*IDX_W-1:0] range;
  logic [IDX_W-1:0] mem_rd_idx;
  logic mem_rd_en;
  logic [7:0] mem_rd_data;
  logic byp_en;
  logic [7:0] byp_data;
  logic [7:0] rst_cause_rd;
  logic opt_wr;

  nvmac_opt_if opt_bus ();

  assign run = (state_q == NVMAC_RUN);
  assign arr_hit = in_array(addr_i);

  // ****************************************************************
  // Block protection
  // ****************************************************************
  // An erased protect byte leaves the whole array open. The protect
  // byte itself stays writable so protection can be changed.
  assign prot_on = !MASK_VARIANT && (prot_q != ERASED_BYTE);
  assign prot_start = {PROT_START_TOP, prot_q, 6'h00};
  assign locked = prot_on && (addr_i >= prot_start) &&
                  (addr_i != PROT_ADDR);

  // ****************************************************************
  // Program and erase
  // ****************************************************************
  // The mask part has no write path into the array at all, so any
  // loader programming attempt falls through here.
  assign erase_en = !MASK_VARIANT && run && wr_i && arr_hit && !locked &&
                    ctrl_q[CTRL_ERASE_BIT];
  assign prog_en = !MASK_VARIANT && run && wr_i && arr_hit && !locked &&
                   ctrl_q[CTRL_PGM_BIT] &&
                   !ctrl_q[CTRL_ERASE_BIT];
  assign range = page_range(addr_i);

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i || MASK_VARIANT)
    begin
      ctrl_q <= CTRL_RESET;
    end
    else if (run && wr_i && addr_i == CTRL_ADDR)
    begin
      ctrl_q <= wdata_i & CTRL_WR_MASK;
    end
  end

  // ****************************************************************
  // Start-up scan of reset vector and protect byte
  // ****************************************************************
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      NVMAC_VEC_HI: state_d = NVMAC_VEC_LO;
      NVMAC_VEC_LO: state_d = NVMAC_PROT;
      NVMAC_PROT: state_d = NVMAC_CHECK;
      NVMAC_CHECK: state_d = NVMAC_RUN;
      NVMAC_RUN: state_d = NVMAC_RUN;
      default: state_d = NVMAC_VEC_HI;
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      state_q <= NVMAC_VEC_HI;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      ready_q <= 1'b0;
    end
    else
    begin
      ready_q <= (state_d == NVMAC_RUN);
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (state_q == NVMAC_VEC_LO)
    begin
      vec_hi_q <= mem_rd_data;
    end
  end

  // A blank reset vector sends the erasable part into the loader.
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      force_q <= 1'b0;
    end
    else if (state_q == NVMAC_PROT)
    begin
      force_q <= !MASK_VARIANT &&
                 ({vec_hi_q, mem_rd_data} == BLANK_VECTOR);
    end
  end

  // Shadow of the protect byte so protection checks need no read port.
  always_ff @(posedge sys_clk_i)
  begin
    if (state_q == NVMAC_CHECK)
    begin
      prot_q <= mem_rd_data;
    end
    else if (erase_en && addr_i == PROT_ADDR)
    begin
      prot_q <= ERASED_BYTE;
    end
    else if (prog_en && addr_i == PROT_ADDR)
    begin
      prot_q <= prot_q & wdata_i;
    end
  end

  // ****************************************************************
  // Reset cause
  // ****************************************************************
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      rst_cause_q <= rst_cause_i & ~(8'h01 << RC_FORCED_BIT);
    end
    else if (state_q == NVMAC_CHECK && !MASK_VARIANT)
    begin
      rst_cause_q[RC_FORCED_BIT] <= force_q;
    end
  end

  always_comb
  begin
    rst_cause_rd = rst_cause_q;
    if (MASK_VARIANT)
    begin
      rst_cause_rd[RC_FORCED_BIT] = 1'b0;
    end
  end

  // ****************************************************************
  // Option registers
  // ****************************************************************
  assign opt_wr = run && wr_i && (addr_i == OPT1_ADDR || addr_i == OPT2_ADDR);
  assign opt_bus.wr_en = opt_wr;
  assign opt_bus.sel_second = (addr_i == OPT2_ADDR);
  assign opt_bus.wdata = wdata_i;

  nvmac_opt #(
    .MASK_VARIANT(MASK_VARIANT),
    .OPT1_MASK_VAL(OPT1_MASK_VAL),
    .OPT2_MASK_VAL(OPT2_MASK_VAL)
  ) u_opt (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .opt(opt_bus.regs)
  );

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Register reads pass through the array's read register so that
  // every read answer leaves from one flip-flop.
  always_comb
  begin
    mem_rd_idx = arr_idx(addr_i);
    mem_rd_en = run && rd_i;
    byp_en = 1'b1;
    byp_data = UNMAPPED_DATA;
    unique case (state_q)
      NVMAC_VEC_HI:
      begin
        mem_rd_idx = arr_idx(RST_VEC_HI_ADDR);
        mem_rd_en = 1'b1;
        byp_en = 1'b0;
      end
      NVMAC_VEC_LO:
      begin
        mem_rd_idx = arr_idx(RST_VEC_LO_ADDR);
        mem_rd_en = 1'b1;
        byp_en = 1'b0;
      end
      NVMAC_PROT:
      begin
        mem_rd_idx = PROT_IDX;
        mem_rd_en = 1'b1;
        byp_en = 1'b0;
      end
      NVMAC_CHECK:
      begin
        mem_rd_en = 1'b0;
      end
      NVMAC_RUN:
      begin
        if (arr_hit)
        begin
          byp_en = secure_lock_i;
          byp_data = SECURE_DATA;
        end
        else if (addr_i == RST_CAUSE_ADDR)
        begin
          byp_data = rst_cause_rd;
        end
        else if (addr_i == CTRL_ADDR)
        begin
          byp_data = ctrl_q;
        end
        else if (addr_i == OPT1_ADDR)
        begin
          byp_data = opt_bus.opt1;
        end
        else if (addr_i == OPT2_ADDR)
        begin
          byp_data = opt_bus.opt2;
        end
      end
      default:
      begin
        mem_rd_en = 1'b0;
      end
    endcase
  end

  nvmac_mem #(
    .WORDS(MEM_WORDS)
  ) u_mem (
    .sys_clk_i(sys_clk_i),
    .rd_en_i(mem_rd_en),
    .rd_idx_i(mem_rd_idx),
    .byp_en_i(byp_en),
    .byp_data_i(byp_data),
    .prog_en_i(prog_en),
    .prog_idx_i(arr_idx(addr_i)),
    .prog_data_i(wdata_i),
    .erase_en_i(erase_en),
    .erase_lo_i(range[IDX_W-1:0]),
    .erase_hi_i(range[2*IDX_W-1:IDX_W]),
    .rd_data_o(mem_rd_data)
  );

  assign rdata_o = mem_rd_data;
  assign ready_o = ready_q;
  assign force_debug_o = force_q;
  assign opt1_o = opt_bus.opt1;
  assign opt2_o = opt_bus.opt2;

endmodule

// ### verilog/nvmac_pkg.sv
// Shared constants and types for the nonvolatile array and option registers.
package nvmac_pkg;

  // ****************************************************************
  // Bus widths
  // ****************************************************************
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // ****************************************************************
  // Address map
  // ****************************************************************
  localparam logic [15:0] USER_BASE = 16'hF600;
  localparam logic [15:0] USER_LAST = 16'hFDFF;
  localparam logic [15:0] VEC_BASE = 16'hFFDC;
  localparam logic [15:0] VEC_LAST = 16'hFFFF;
  localparam logic [15:0] RST_VEC_HI_ADDR = 16'hFFFE;
  localparam logic [15:0] RST_VEC_LO_ADDR = 16'hFFFF;
  localparam logic [15:0] PROT_ADDR = 16'hFF7E;
  localparam logic [15:0] RST_CAUSE_ADDR = 16'hFE01;
  localparam logic [15:0] CTRL_ADDR = 16'hFE08;
  localparam logic [15:0] OPT1_ADDR = 16'h001F;
  localparam logic [15:0] OPT2_ADDR = 16'h001E;

  // ****************************************************************
  // Array organisation
  // ****************************************************************
  localparam int USER_BYTES = 2048;
  localparam int VEC_BYTES = 36;
  localparam int PROT_BYTES = 1;
  localparam int MEM_WORDS = USER_BYTES + VEC_BYTES + PROT_BYTES;
  localparam int IDX_W = 12;
  localparam logic [IDX_W-1:0] VEC_IDX = 12'h800;
  localparam logic [IDX_W-1:0] VEC_IDX_LAST = 12'h823;
  localparam logic [IDX_W-1:0] PROT_IDX = 12'h824;
  localparam int ROW_BYTES = 32;
  localparam int PAGE_ROWS = 2;
  localparam int PAGE_BYTES = ROW_BYTES * PAGE_ROWS;
  localparam logic [IDX_W-1:0] PAGE_MASK = IDX_W'(PAGE_BYTES - 1);
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [15:0] BLANK_VECTOR = 16'hFFFF;
  localparam logic [1:0] PROT_START_TOP = 2'h3;

  // ****************************************************************
  // Register fields and reset values
  // ****************************************************************
  localparam int CTRL_PGM_BIT = 0;
  localparam int CTRL_ERASE_BIT = 1;
  localparam logic [7:0] CTRL_WR_MASK = 8'h03;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int RC_FORCED_BIT = 2;
  localparam int OPT2_PUMP_BIT = 2;
  localparam logic [7:0] OPT1_RESET = 8'h00;
  localparam logic [7:0] OPT2_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;
  localparam logic [7:0] SECURE_DATA = 8'h00;

  // ****************************************************************
  // Start-up sequence
  // ****************************************************************
  typedef enum logic [4:0] {
    NVMAC_VEC_HI = 5'b00001,
    NVMAC_VEC_LO = 5'b00010,
    NVMAC_PROT = 5'b00100,
    NVMAC_CHECK = 5'b01000,
    NVMAC_RUN = 5'b10000
  } nvmac_state_t;

endpackage

// ### verilog/nvmac_opt_if.sv
// Link between the main block and the option register module.
`timescale 1ns/1ps
interface nvmac_opt_if;
  logic wr_en;
  logic sel_second;
  logic [7:0] wdata;
  logic [7:0] opt1;
  logic [7:0] opt2;

  modport ctl
  (
    output wr_en,
    output sel_second,
    output wdata,
    input opt1,
    input opt2
  );

  modport regs
  (
    input wr_en,
    input sel_second,
    input wdata,
    output opt1,
    output opt2
  );
endinterface

// ### verilog/nvmac_mem.sv
// Byte array with one-cycle page erase, AND-programming and registered read.
`timescale 1ns/1ps
module nvmac_mem
  import nvmac_pkg::*;
#(
  parameter int WORDS = MEM_WORDS
)
(
  input wire logic sys_clk_i,              // System clock.
  input wire logic rd_en_i,                // Load read register.
  input wire logic [IDX_W-1:0] rd_idx_i,   // Read word index.
  input wire logic byp_en_i,               // Return bypass data instead.
  input wire logic [7:0] byp_data_i,       // Bypass read data.
  input wire logic prog_en_i,              // Program one byte.
  input wire logic [IDX_W-1:0] prog_idx_i, // Program word index.
  input wire logic [7:0] prog_data_i,      // Program data.
  input wire logic erase_en_i,             // Erase a page.
  input wire logic [IDX_W-1:0] erase_lo_i, // First word of the page.
  input wire logic [IDX_W-1:0] erase_hi_i, // Last word of the page.
  output logic [7:0] rd_data_o             // Registered read data.
);

  logic [7:0] mem_q [WORDS];
  logic [7:0] rd_q;

  // ****************************************************************
  // Array update
  // ****************************************************************
  // Nonvolatile contents carry no reset.
  always_ff @(posedge sys_clk_i)
  begin
    for (int i = 0; i < WORDS; i++)
    begin
      if (erase_en_i && (IDX_W'(i) >= erase_lo_i) &&
          (IDX_W'(i) <= erase_hi_i))
      begin
        mem_q[i] <= ERASED_BYTE;
      end
      else if (prog_en_i && (IDX_W'(i) == prog_idx_i))
      begin
        // Programming can only clear bits; a one needs an erase.
        mem_q[i] <= mem_q[i] & prog_data_i;
      end
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  always_ff @(posedge sys_clk_i)
  begin
    if (rd_en_i)
    begin
      rd_q <= byp_en_i ? byp_data_i : mem_q[rd_idx_i];
    end
  end

  assign rd_data_o = rd_q;

endmodule

// ### verilog/nvmac_opt.sv
// Option registers: write-once on the erasable part, fixed on the mask part.
`timescale 1ns/1ps
module nvmac_opt
  import nvmac_pkg::*;
#(
  parameter bit MASK_VARIANT = 1'b0,
  parameter logic [7:0] OPT1_MASK_VAL = 8'h00,
  parameter logic [7:0] OPT2_MASK_VAL = 8'h00
)
(
  input wire logic sys_clk_i,  // System clock.
  input wire logic sys_rst_i,  // Synchronous reset, active high.
  nvmac_opt_if.regs opt        // Write port and option values.
);

  logic [7:0] opt1_q;
  logic [7:0] opt2_q;
  logic done1_q;
  logic done2_q;
  logic [7:0] opt2_fixed;

  // The pump regulator disable has no function on the mask part.
  always_comb
  begin
    opt2_fixed = OPT2_MASK_VAL;
    opt2_fixed[OPT2_PUMP_BIT] = 1'b0;
  end

  // ****************************************************************
  // Option registers
  // ****************************************************************
  always_ff @(posedge sys_clk_i)
  begin
    if (MASK_VARIANT)
    begin
      opt1_q <= OPT1_MASK_VAL;
      opt2_q <= opt2_fixed;
      done1_q <= 1'b1;
      done2_q <= 1'b1;
    end
    else if (sys_rst_i)
    begin
      opt1_q <= OPT1_RESET;
      opt2_q <= OPT2_RESET;
      done1_q <= 1'b0;
      done2_q <= 1'b0;
    end
    else if (opt.wr_en)
    begin
      // Only the first write after reset lands in each register.
      if (opt.sel_second && !done2_q)
      begin
        opt2_q <= opt.wdata;
        done2_q <= 1'b1;
      end
      else if (!opt.sel_second && !done1_q)
      begin
        opt1_q <= opt.wdata;
        done1_q <= 1'b1;
      end
    end
  end

  assign opt.opt1 = opt1_q;
  assign opt.opt2 = opt2_q;

endmodule

// ### tb/nvmac_monitor.sv
// Port-level checker for the nonvolatile access block.
`timescale 1ns/1ps
module nvmac_monitor
  import nvmac_pkg::*;
#(
  parameter bit MASK_VARIANT = 1'b0,
  parameter logic [7:0] OPT1_MASK_VAL = 8'h00,
  parameter logic [7:0] OPT2_MASK_VAL = 8'h00
)
(
  input wire logic sys_clk_i,          // Clock.
  input wire logic sys_rst_i,          // Reset.
  input wire logic [ADDR_W-1:0] addr_i, // Address.
  input wire logic wr_i,               // Write strobe.
  input wire logic rd_i,               // Read strobe.
  input wire logic secure_lock_i,      // Read lock.
  input wire logic [DATA_W-1:0] rdata_o, // Read data.
  input wire logic ready_o,            // Ready.
  input wire logic force_debug_o,      // Forced entry.
  input wire logic [7:0] opt1_o,       // Option one.
  input wire logic [7:0] opt2_o        // Option two.
);
  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking mon_cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  chk_mask_cause_bit: assert property (MASK_VARIANT && ready_o && rd_i
    && addr_i == RST_CAUSE_ADDR |=> !rdata_o[RC_FORCED_BIT])
    else $error("Reset-cause bit 2 set on mask part.");
  chk_cause_tracks_entry: assert property (!MASK_VARIANT && ready_o
    && rd_i && addr_i == RST_CAUSE_ADDR |=> rdata_o[2] == force_debug_o)
    else $error("Reset-cause bit 2 differs from forced entry.");
  chk_pump_bit_zero: assert property (MASK_VARIANT |-> !opt2_o[2])
    else $error("Pump disable bit reads one on mask part.");
  chk_mask_opt_fixed: assert property (MASK_VARIANT |->
    opt1_o == OPT1_MASK_VAL && opt2_o == (OPT2_MASK_VAL & 8'hFB))
    else $error("Mask option values moved.");
  chk_no_forced_entry: assert property (MASK_VARIANT |-> !force_debug_o)
    else $error("Forced entry on mask part.");
  chk_opt_write_once: assert property (!MASK_VARIANT && $changed(opt1_o)
    |-> $past(wr_i) && $past(addr_i) == OPT1_ADDR
    && $past(opt1_o) == OPT1_RESET)
    else $error("Option register changed without first write.");
  chk_secure_read_zero: assert property (secure_lock_i && ready_o
    && rd_i && addr_i >= USER_BASE && addr_i <= USER_LAST
    |=> rdata_o == SECURE_DATA)
    else $error("Locked array read returned data.");
  chk_ctrl_read_bits: assert property (ready_o && rd_i
    && addr_i == CTRL_ADDR
    |=> (MASK_VARIANT ? rdata_o == 8'h00 : rdata_o[7:2] == 6'h00))
    else $error("Control register unused bits set.");
  chk_unmapped_zero: assert property (ready_o && rd_i
    && addr_i[15:8] == 8'h01 |=> rdata_o == UNMAPPED_DATA)
    else $error("Unmapped read returned data.");
  chk_ready_start: assert property ($fell(sys_rst_i)
    |-> !ready_o [*4] ##1 ready_o)
    else $error("Ready not on fifth edge after reset.");
  chk_entry_steady: assert property (ready_o && $past(ready_o)
    |-> $stable(force_debug_o))
    else $error("Forced entry changed in run.");
endmodule

bind nvmac_top nvmac_monitor #(
  .MASK_VARIANT(MASK_VARIANT),
  .OPT1_MASK_VAL(OPT1_MASK_VAL),
  .OPT2_MASK_VAL(OPT2_MASK_VAL)
) mon_u (
  .sys_clk_i(sys_clk_i),
  .sys_rst_i(sys_rst_i),
  .addr_i(addr_i),
  .wr_i(wr_i),
  .rd_i(rd_i),
  .secure_lock_i(secure_lock_i),
  .rdata_o(rdata_o),
  .ready_o(ready_o),
  .force_debug_o(force_debug_o),
  .opt1_o(opt1_o),
  .opt2_o(opt2_o)
);

// ### tb/nvmac_top_tb_top.sv
// Self-checking bench driving an erasable and a mask instance side by side.
`timescale 1ns/1ps
module nvmac_top_tb_top
  import nvmac_pkg::*;
;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [15:0] addr_i = 16'h0000;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rst_cause_i = 8'h00;
  logic secure_lock_i = 1'b0;
  logic [7:0] rd_e, rd_m, op1_e, op2_e, op1_m, op2_m, got_e, got_m;
  logic rdy_e, rdy_m, dbg_e, dbg_m;
  int fail_count = 0;
  int cmp_count = 0;

  always #12.5 sys_clk_i = ~sys_clk_i;

  nvmac_top #(.MASK_VARIANT(1'b0)) dut_u (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rst_cause_i(rst_cause_i),
    .secure_lock_i(secure_lock_i), .rdata_o(rd_e), .ready_o(rdy_e),
    .force_debug_o(dbg_e), .opt1_o(op1_e), .opt2_o(op2_e));
  nvmac_top #(.MASK_VARIANT(1'b1), .OPT1_MASK_VAL(8'h3C),
    .OPT2_MASK_VAL(8'hFF)) dut_m_u (
    .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rst_cause_i(rst_cause_i),
    .secure_lock_i(secure_lock_i), .rdata_o(rd_m), .ready_o(rdy_m),
    .force_debug_o(dbg_m), .opt1_o(op1_m), .opt2_o(op2_m));

  // ****************************************************************
  // Bus tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [7:0] got,
    input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    got_e = rd_e;
    got_m = rd_m;
  endtask

  task automatic rchk(input string nm, input logic [15:0] a,
    input logic [7:0] exp);
    rd(a);
    chk(nm, got_e, exp);
  endtask

  task automatic do_reset(input logic [7:0] c);
    @(posedge sys_clk_i);
    sys_rst_i <= 1'b1;
    rst_cause_i <= c;
    repeat (5) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    #1;
    chk("ready early", {6'h00, rdy_e, rdy_m}, 8'h00);
    @(posedge sys_clk_i);
    #1;
    chk("ready", {6'h00, rdy_e, rdy_m}, 8'h03);
  endtask

  task automatic end_of_test();
    if (fail_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial
  begin
    repeat (2000) @(posedge sys_clk_i);
    fail_count++;
    end_of_test();
  end

  initial
  begin
    do_reset(8'hA5);
    chk("mask debug", {7'h00, dbg_m}, 8'h00);
    chk("mask opt1", op1_m, 8'h3C);
    chk("mask opt2", op2_m, 8'hFB);
    // The array starts unknown, so the forced-entry decision is unknown
    // too. Clear the protect byte and vectors and restart before any
    // read, the reset cause included, relies on their contents.
    wr(CTRL_ADDR, 8'h02);
    wr(PROT_ADDR, 8'h00);
    wr(VEC_BASE, 8'h00);
    do_reset(8'hA5);
    rd(RST_CAUSE_ADDR);
    chk("mask cause", got_m, 8'hA1);
    do_reset(8'h81);
    chk("blank vector entry", {7'h00, dbg_e}, 8'h01);
    rd(RST_CAUSE_ADDR);
    chk("cause", got_e, 8'h85);
    chk("mask cause", got_m, 8'h81);
    chk("opt1 reset", op1_e, OPT1_RESET);
    wr(OPT1_ADDR, 8'h5A);
    wr(OPT1_ADDR, 8'h33);
    wr(OPT2_ADDR, 8'h44);
    wr(OPT2_ADDR, 8'h11);
    #1;
    chk("opt1 once", op1_e, 8'h5A);
    chk("opt2 once", op2_e, 8'h44);
    chk("mask opt1 fixed", op1_m, 8'h3C);
    chk("mask opt2 fixed", op2_m, 8'hFB);
    wr(CTRL_ADDR, 8'hFF);
    rd(CTRL_ADDR);
    chk("ctrl", got_e, 8'h03);
    chk("mask ctrl", got_m, 8'h00);
    wr(CTRL_ADDR, 8'h02);
    wr(16'hF600, 8'h00);
    wr(16'hF640, 8'h00);
    wr(CTRL_ADDR, 8'h01);
    wr(16'hF63F, 8'h5A);
    wr(CTRL_ADDR, 8'h02);
    wr(16'hF67F, 8'h00);
    rchk("lower row pair", 16'hF63F, 8'h5A);
    rchk("page first", 16'hF640, 8'hFF);
    rchk("page last", 16'hF67F, 8'hFF);
    wr(CTRL_ADDR, 8'h01);
    wr(16'hF640, 8'h3C);
    wr(16'hF640, 8'h0F);
    rchk("program and", 16'hF640, 8'h0C);
    rchk("program one byte", 16'hF641, 8'hFF);
    wr(CTRL_ADDR, 8'h02);
    wr(USER_LAST, 8'h00);
    rchk("user top", USER_LAST, 8'hFF);
    rchk("vector top", VEC_LAST, 8'hFF);
    rchk("below user", 16'hF5FF, 8'h00);
    rchk("unmapped", 16'h0100, 8'h00);
    rchk("vector first", VEC_BASE, 8'hFF);
    rchk("below vectors", 16'hFFDB, 8'h00);
    @(posedge sys_clk_i);
    secure_lock_i <= 1'b1;
    rd(16'hF640);
    chk("secure", got_e, SECURE_DATA);
    chk("mask secure", got_m, SECURE_DATA);
    end_of_test();
  end
endmodule
